/* hdl/dmac_core.sv */
// Four-channel DMA controller with AXI4-Lite registers and a memory master
//
// Operation
// - Control bit 15 enables the transfer engine; registers stay accessible when it is clear
// - Suspend bit 12 stops issuing new transfers
// - Busy bit 11 shows activity, zero when disabled
// - Four identical channels with source, destination pointers
// - Pointers advance as data is moved
// - Memory or peripheral addresses on either side
// - Word moves when aligned with four bytes left on both sides, otherwise single bytes
// - Fixed priority: lowest channel number wins
// - Requests from software or selected interrupt line
// - One-shot, auto-repeat and chaining to next channel
// - Any interrupt line selectable as start trigger
// - Selected interrupt aborts and flags abort event
// - Pattern match on moved byte ends transfer
// - Block completion raises done event
// - Source half/end, destination half/full events
// - Invalid bus address raises error event
// - Status bits 2:0 hold last channel
// - Status bit 3: last access was read
// - Address of most recent access captured
// - Checksum unit attachable to any channel
// - Bus master to any mapped address
`timescale 1ns/1ps
module dmac_core #(
  parameter int NIRQ = 64
) (
  // Clock and reset
  input  wire logic            mclk,
  input  wire logic            rst_n,
  // AXI4-Lite write address and data
  input  wire logic [11:0]     s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  // AXI4-Lite write response
  output logic      [1:0]      s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0]     s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic      [31:0]     s_axi_rdata,
  output logic      [1:0]      s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  // Interrupt event lines used as triggers
  input  wire logic [NIRQ-1:0] irqIn,
  // Memory bus master
  output logic                 memReq,
  output logic                 memWrite,
  output logic      [31:0]     memAddr,
  output logic      [3:0]      memBe,
  output logic      [31:0]     memWdata,
  input  wire logic [31:0]     memRdata,
  input  wire logic            memAck,
  input  wire logic            memErr
);
  import dmac_pkg::*;
  localparam int NCH = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  dmac_state_t state_q;
  logic [31:0] glbCtrl_q;
  logic        busy_q, lastDir_q;
  logic [2:0]  lastCh_q;
  logic [31:0] lastAddr_q;
  logic [7:0]  cksCtrl_q;
  logic [15:0] cksSum_q;
  logic [1:0]  curCh_q;
  logic        curWord_q;
  logic [31:0] moved_q;
  logic [31:0] dstA_q;
  logic [NCH-1:0] grant_q, err_q;
  logic [2:0]  step_q;
  logic [NCH-1:0] req, wOk, chain;
  logic [31:0] srcA [NCH];
  logic [31:0] dstA [NCH];
  logic [31:0] chRd [NCH];

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  wire awTake = s_axi_awready && s_axi_awvalid;
  wire arTake = s_axi_arready && s_axi_arvalid;
  wire wrCh   = s_axi_awaddr[CH_ADR_BIT];
  wire rdCh   = s_axi_araddr[CH_ADR_BIT];
  wire [1:0] wrChIdx = s_axi_awaddr[6:5];
  wire [1:0] rdChIdx = s_axi_araddr[6:5];
  wire [2:0] wrReg   = s_axi_awaddr[4:2];
  wire [2:0] rdReg   = s_axi_araddr[4:2];
  // Whole-word writes only
  wire wrFull  = (s_axi_wstrb == 4'hF);
  wire wrOkCh  = wrCh && (wrReg <= CH_FLAG_IDX);
  wire wrOkGl  = !wrCh && ((s_axi_awaddr == GLB_CTRL_OFS) ||
                 (s_axi_awaddr == CKS_CTRL_OFS) || (s_axi_awaddr == CKS_SUM_OFS));
  wire wrRoGl  = !wrCh && ((s_axi_awaddr == GLB_STAT_OFS) ||
                 (s_axi_awaddr == LAST_ADR_OFS));
  wire wrHit   = wrOkCh || wrOkGl || wrRoGl;
  wire wrDo    = awTake && wrFull && (wrOkCh || wrOkGl);
  wire rdOkCh  = rdCh && (rdReg <= CH_FLAG_IDX);
  wire rdOkGl  = !rdCh && ((s_axi_araddr == GLB_CTRL_OFS) || (s_axi_araddr == GLB_STAT_OFS) ||
                 (s_axi_araddr == LAST_ADR_OFS) || (s_axi_araddr == CKS_CTRL_OFS) ||
                 (s_axi_araddr == CKS_SUM_OFS));
  // Global write strobes
  wire glbWe   = wrDo && !wrCh && (s_axi_awaddr == GLB_CTRL_OFS);
  wire cksCWe  = wrDo && !wrCh && (s_axi_awaddr == CKS_CTRL_OFS);
  wire cksSWe  = wrDo && !wrCh && (s_axi_awaddr == CKS_SUM_OFS);

  // Global read data
  wire [31:0] glbRdCtrl = {16'h0000, glbCtrl_q[15:12], busy_q, 11'h000};
  wire [31:0] glbRdStat = {28'h0000000, lastDir_q, lastCh_q};
  wire [31:0] glbRd =
    (s_axi_araddr == GLB_CTRL_OFS) ? glbRdCtrl :
    (s_axi_araddr == GLB_STAT_OFS) ? glbRdStat :
    (s_axi_araddr == LAST_ADR_OFS) ? lastAddr_q :
    (s_axi_araddr == CKS_CTRL_OFS) ? {24'h000000, cksCtrl_q} :
    (s_axi_araddr == CKS_SUM_OFS)  ? {16'h0000, cksSum_q} : 32'h0000_0000;
  wire [31:0] rdMux = rdOkCh ? chRd[rdChIdx] : (rdOkGl ? glbRd : 32'h0000_0000);

  // Write channel handshake: address and data taken together
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OK;
    end else begin
      // Readies pulse once per write
      s_axi_awready <= !s_axi_awready && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
      s_axi_wready  <= !s_axi_awready && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
      if (awTake) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrHit ? RESP_OK : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel handshake
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OK;
    end else begin
      // Ready pulses once per read
      s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
      if (arTake) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdMux;
        s_axi_rresp  <= (rdOkCh || rdOkGl) ? RESP_OK : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channels, each chained to its lower neighbour, channel 0 to channel 3
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    dmac_channel #(
      .NIRQ(NIRQ)
    ) u_ch (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .regWe    (wrDo && wrCh && (wrChIdx == 2'(c))),
      .wrSel    (wrReg),
      .regWdata (s_axi_wdata),
      .rdSel    (rdReg),
      .rdData   (chRd[c]),
      .irqIn    (irqIn),
      .chainIn  ((c == 0) ? chain[NCH-1] : chain[(c + NCH - 1) % NCH]),
      .chainOut (chain[c]),
      .grant    (grant_q[c]),
      .busErr   (err_q[c]),
      .step     (step_q),
      .moveByte (moved_q[7:0]),
      .reqPend  (req[c]),
      .srcAddr  (srcA[c]),
      .dstAddr  (dstA[c]),
      .wordOk   (wOk[c])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fixed priority arbiter
  logic [1:0] winCh;
  always_comb begin
    winCh = 2'd0;
    // Downward scan: channel 0 wins
    for (int i = NCH - 1; i >= 0; i--) begin
      if (req[i]) winCh = 2'(i);
    end
  end
  // Start gate of the engine
  wire enOn   = glbCtrl_q[ON_BIT];
  wire mayRun = enOn && !glbCtrl_q[SUSP_BIT] && (|req);

  // Byte lane handling for unaligned moves
  wire [4:0]  srcSh   = {srcA[winCh][1:0], 3'b000};
  wire [31:0] rdShift = memRdata >> {memAddr[1:0], 3'b000};
  wire [31:0] rdData  = curWord_q ? memRdata : {24'h000000, rdShift[7:0]};
  wire [3:0]  byteBe  = 4'h1 << dstA_q[1:0];
  wire        unusedSh = |srcSh;

  ////////////////////////////////////////////////////////////////////////////
  // Transfer engine: one read, then one write, per grant
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= DMAC_IDLE;
      memReq    <= 1'b0;
      memWrite  <= 1'b0;
      memAddr   <= 32'h0000_0000;
      memBe     <= 4'h0;
      memWdata  <= 32'h0000_0000;
      curCh_q   <= 2'd0;
      curWord_q <= 1'b0;
      moved_q   <= 32'h0000_0000;
      dstA_q    <= 32'h0000_0000;
      grant_q   <= '0;
      err_q     <= '0;
      step_q    <= 3'd1;
    end else begin
      grant_q <= '0;
      err_q   <= '0;
      if (!enOn) begin
        state_q <= DMAC_IDLE;
        memReq  <= 1'b0;
      end else begin
        case (state_q)
          DMAC_IDLE: begin
            // Let pointers settle first
            if (mayRun && grant_q == '0 && err_q == '0) begin
              state_q   <= DMAC_RD;
              memReq    <= 1'b1;
              memWrite  <= 1'b0;
              memAddr   <= {srcA[winCh][31:2], wOk[winCh] ? 2'b00 : srcA[winCh][1:0]};
              memBe     <= wOk[winCh] ? 4'hF : (4'h1 << srcA[winCh][1:0]);
              curCh_q   <= winCh;
              curWord_q <= wOk[winCh];
              dstA_q    <= dstA[winCh];
              step_q    <= wOk[winCh] ? 3'd4 : 3'd1;
            end
          end
          DMAC_RD: begin
            if (memAck) begin
              // Failed read: no write
              if (memErr) begin
                state_q         <= DMAC_IDLE;
                memReq          <= 1'b0;
                err_q[curCh_q]  <= 1'b1;
              end else begin
                state_q  <= DMAC_WR;
                moved_q  <= rdData;
                memWrite <= 1'b1;
                memAddr  <= dstA_q;
                memBe    <= curWord_q ? 4'hF : byteBe;
                memWdata <= curWord_q ? rdData : {4{rdData[7:0]}};
              end
            end
          end
          DMAC_WR: begin
            if (memAck) begin
              state_q <= DMAC_IDLE;
              memReq  <= 1'b0;
              // Grant advances the pointers
              if (memErr) err_q[curCh_q] <= 1'b1;
              else grant_q[curCh_q] <= 1'b1;
            end
          end
          default: begin
            state_q <= DMAC_IDLE;
            memReq  <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Global control and busy flag
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      glbCtrl_q <= GLB_RST;
      busy_q    <= 1'b0;
    end else begin
      if (glbWe) begin
        glbCtrl_q[ON_BIT]   <= s_axi_wdata[ON_BIT];
        glbCtrl_q[SUSP_BIT] <= s_axi_wdata[SUSP_BIT];
      end
      // Busy lags by one cycle
      busy_q <= enOn && ((state_q != DMAC_IDLE) || (|req));
    end
  end

  // Debug capture of the most recent access
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lastCh_q   <= 3'd0;
      lastDir_q  <= 1'b0;
      lastAddr_q <= 32'h0000_0000;
    end else if (enOn && memReq && memAck) begin
      lastCh_q   <= {1'b0, curCh_q};
      lastDir_q  <= !memWrite;
      lastAddr_q <= memAddr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checksum unit: 16-bit end-around-carry sum of moved data
  wire        cksHit = cksCtrl_q[CKS_EN_BIT] && (grant_q[cksCtrl_q[1:0]]) &&
                       (cksCtrl_q[2] == 1'b0);
  wire [17:0] cksAdd = {2'b00, cksSum_q} + {2'b00, moved_q[15:0]} +
                       {2'b00, moved_q[31:16]};
  // Fold carries into low half
  wire [17:0] cksFold = {16'h0000, cksAdd[17:16]} + {2'b00, cksAdd[15:0]};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cksCtrl_q <= 8'h00;
      cksSum_q  <= 16'h0000;
    end else begin
      if (cksCWe) cksCtrl_q <= {s_axi_wdata[CKS_EN_BIT], 4'h0, s_axi_wdata[2:0]};
      if (cksSWe) cksSum_q <= s_axi_wdata[15:0];
      else if (cksHit) cksSum_q <= cksFold[15:0] + {15'h0000, cksFold[16]};
    end
  end

  // Software keeps off the registers one cycle after clearing enable
  // (nothing to enforce here; every access is still answered)
  wire unusedTie = unusedSh;
endmodule : dmac_core

/* hdl/dmac_pkg.sv */
// Shared constants and types of the four-channel DMA controller
package dmac_pkg;
  // Global register byte offsets
  localparam logic [11:0] GLB_CTRL_OFS = 12'h000;
  localparam logic [11:0] GLB_STAT_OFS = 12'h004;
  localparam logic [11:0] LAST_ADR_OFS = 12'h008;
  localparam logic [11:0] CKS_CTRL_OFS = 12'h00C;
  localparam logic [11:0] CKS_SUM_OFS  = 12'h010;
  // Channel windows: bit 7 set, channel in [6:5], register in [4:2]
  localparam int          CH_ADR_BIT   = 7;
  localparam logic [2:0]  CH_CTRL_IDX  = 3'h0;
  localparam logic [2:0]  CH_SRC_IDX   = 3'h1;
  localparam logic [2:0]  CH_DST_IDX   = 3'h2;
  localparam logic [2:0]  CH_SIZE_IDX  = 3'h3;
  localparam logic [2:0]  CH_PAT_IDX   = 3'h4;
  localparam logic [2:0]  CH_FLAG_IDX  = 3'h5;
  // Global control and status fields
  localparam int          ON_BIT       = 15;
  localparam int          SUSP_BIT     = 12;
  localparam int          BUSY_BIT     = 11;
  localparam int          DIR_BIT      = 3;
  localparam logic [31:0] GLB_RST      = 32'h0000_0000;
  // Checksum control fields
  localparam int          CKS_EN_BIT   = 7;
  // Channel control fields
  localparam int          CC_EN        = 0;
  localparam int          CC_AUTO      = 1;
  localparam int          CC_CHAIN     = 2;
  localparam int          CC_TRIG      = 3;
  localparam int          CC_ABORT     = 4;
  localparam int          CC_PAT       = 5;
  localparam int          CC_FORCE     = 7;
  localparam int          CC_TSEL      = 8;
  localparam int          CC_ASEL      = 16;
  localparam logic [31:0] CC_MASK      = 32'h00FF_FF3F;
  // Channel event flag positions
  localparam int          EV_ABORT     = 0;
  localparam int          EV_ERR       = 1;
  localparam int          EV_DONE      = 2;
  localparam int          EV_SHALF     = 3;
  localparam int          EV_SEND      = 4;
  localparam int          EV_DHALF     = 5;
  localparam int          EV_DFULL     = 6;
  localparam int          EV_PAT       = 7;
  // Bus answers
  localparam logic [1:0]  RESP_OK      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  // Engine states, Gray along idle-read-write
  typedef enum logic [1:0] {
    DMAC_IDLE = 2'b00,
    DMAC_RD   = 2'b01,
    DMAC_WR   = 2'b11
  } dmac_state_t;
endpackage : dmac_pkg

/* hdl/dmac_channel.sv */
// One DMA channel: registers, pointers, triggers and event flags
`timescale 1ns/1ps
module dmac_channel #(
  parameter int NIRQ = 64
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Register access
  input  wire logic        regWe,
  input  wire logic [2:0]  wrSel,
  input  wire logic [31:0] regWdata,
  input  wire logic [2:0]  rdSel,
  output logic      [31:0] rdData,
  // Events and chaining
  input  wire logic [NIRQ-1:0] irqIn,
  input  wire logic        chainIn,
  output logic             chainOut,
  // Engine side
  input  wire logic        grant,
  input  wire logic        busErr,
  input  wire logic [2:0]  step,
  input  wire logic [7:0]  moveByte,
  output logic             reqPend,
  output logic      [31:0] srcAddr,
  output logic      [31:0] dstAddr,
  output logic             wordOk
);
  import dmac_pkg::*;
  localparam int SW = $clog2(NIRQ);

  logic [31:0] ctrl_q, srcBase_q, dstBase_q, size_q;
  logic [7:0]  pat_q, flags_q, flags_d, evSet;
  logic [15:0] srcPtr_q, dstPtr_q, srcNew, dstNew, srcSize, dstSize;
  logic        pend_q, chainArm_q, srcDone_q, dstDone_q;

  // Trigger, abort and arming decode
  wire weCtrl  = regWe && (wrSel == CH_CTRL_IDX);
  wire weFlag  = regWe && (wrSel == CH_FLAG_IDX);
  wire trigHit = ctrl_q[CC_TRIG] && irqIn[ctrl_q[CC_TSEL +: SW]];
  wire abtHit  = ctrl_q[CC_ABORT] && irqIn[ctrl_q[CC_ASEL +: SW]] && pend_q;
  wire swForce = weCtrl && regWdata[CC_FORCE];
  wire enNow   = weCtrl ? regWdata[CC_EN] : ctrl_q[CC_EN];
  wire armed   = enNow && (!ctrl_q[CC_CHAIN] || chainArm_q);
  assign srcSize = size_q[15:0];
  assign dstSize = size_q[31:16];
  assign srcNew  = srcPtr_q + 16'(step);
  assign dstNew  = dstPtr_q + 16'(step);
  wire srcEnd  = grant && (srcNew >= srcSize);
  wire dstEnd  = grant && (dstNew >= dstSize);
  wire blkDone = grant && (srcDone_q || srcEnd) && (dstDone_q || dstEnd);
  wire patHit  = grant && ctrl_q[CC_PAT] && (moveByte == pat_q);
  wire stopAll = blkDone || abtHit || patHit || busErr;
  wire keepEn  = blkDone && ctrl_q[CC_AUTO] && !abtHit && !patHit;

  // Event flags; hardware set wins over software clear
  always_comb begin
    evSet = 8'h00;
    evSet[EV_ABORT] = abtHit;
    evSet[EV_ERR]   = busErr;
    evSet[EV_DONE]  = blkDone;
    evSet[EV_SHALF] = grant && (srcPtr_q < srcSize/2) && (srcNew >= srcSize/2);
    evSet[EV_SEND]  = srcEnd;
    evSet[EV_DHALF] = grant && (dstPtr_q < dstSize/2) && (dstNew >= dstSize/2);
    evSet[EV_DFULL] = dstEnd;
    evSet[EV_PAT]   = patHit;
    flags_d = (flags_q & ~(weFlag ? regWdata[7:0] : 8'h00)) | evSet;
  end

  // Register and pointer state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q     <= 32'h0000_0000;
      srcBase_q  <= 32'h0000_0000;
      dstBase_q  <= 32'h0000_0000;
      size_q     <= 32'h0000_0000;
      pat_q      <= 8'h00;
      flags_q    <= 8'h00;
      srcPtr_q   <= 16'h0000;
      dstPtr_q   <= 16'h0000;
      srcDone_q  <= 1'b0;
      dstDone_q  <= 1'b0;
      pend_q     <= 1'b0;
      chainArm_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      if (weCtrl) ctrl_q <= regWdata & CC_MASK;
      else if (stopAll && !keepEn) ctrl_q[CC_EN] <= 1'b0;
      if (regWe && wrSel == CH_SRC_IDX) srcBase_q <= regWdata;
      if (regWe && wrSel == CH_DST_IDX) dstBase_q <= regWdata;
      if (regWe && wrSel == CH_SIZE_IDX) size_q <= regWdata;
      if (regWe && wrSel == CH_PAT_IDX) pat_q <= regWdata[7:0];
      // Chain arming by the lower neighbour's completion
      if (chainIn) chainArm_q <= 1'b1;
      else if (blkDone) chainArm_q <= 1'b0;
      if ((swForce || trigHit) && armed) pend_q <= 1'b1;
      else if (stopAll || !ctrl_q[CC_EN]) pend_q <= 1'b0;
      if (stopAll || weCtrl) begin
        srcPtr_q  <= 16'h0000;
        dstPtr_q  <= 16'h0000;
        srcDone_q <= 1'b0;
        dstDone_q <= 1'b0;
      end else if (grant) begin
        srcPtr_q  <= srcEnd ? 16'h0000 : srcNew;
        dstPtr_q  <= dstEnd ? 16'h0000 : dstNew;
        srcDone_q <= srcDone_q || srcEnd;
        dstDone_q <= dstDone_q || dstEnd;
      end
    end
  end

  // Engine view of the channel
  assign reqPend  = pend_q && ctrl_q[CC_EN];
  assign chainOut = blkDone;
  assign srcAddr  = srcBase_q + {16'h0000, srcPtr_q};
  assign dstAddr  = dstBase_q + {16'h0000, dstPtr_q};
  assign wordOk   = (srcAddr[1:0] == 2'b00) && (dstAddr[1:0] == 2'b00) &&
                    ((srcSize - srcPtr_q) >= 16'h0004) &&
                    ((dstSize - dstPtr_q) >= 16'h0004);

  // Register read mux
  assign rdData = (rdSel == CH_CTRL_IDX) ? ctrl_q :
                  (rdSel == CH_SRC_IDX)  ? srcBase_q :
                  (rdSel == CH_DST_IDX)  ? dstBase_q :
                  (rdSel == CH_SIZE_IDX) ? size_q :
                  (rdSel == CH_PAT_IDX)  ? {24'h000000, pat_q} :
                  (rdSel == CH_FLAG_IDX) ? {24'h000000, flags_q} : 32'h0000_0000;
endmodule : dmac_channel

/* tb/dmac_core_assertions.sv */
// Bus and engine checks on the DMA core ports
`timescale 1ns/1ps
module dmac_core_assertions (
  // Clock, reset and register writes
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Memory master
  input wire logic        memReq,
  input wire logic        memWrite,
  input wire logic [31:0] memAddr,
  input wire logic        memAck,
  input wire logic        memErr
);
  import dmac_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [31:0] ctrl_q;
  // Mirror of full-word control writes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) ctrl_q <= 32'h0;
    else if (s_axi_awvalid && s_axi_awready && s_axi_wstrb == 4'hF && s_axi_awaddr == GLB_CTRL_OFS) ctrl_q <= s_axi_wdata;
  end
  // Engine gating and memory ordering
  chk_off_no_req: assert property (!ctrl_q[ON_BIT] [*2] |-> !memReq) else $error("request while off");
  chk_susp_hold: assert property (ctrl_q[SUSP_BIT] && $past(ctrl_q[SUSP_BIT]) && !memReq |=> !memReq) else $error("start while suspended");
  chk_mem_stable: assert property (memReq && !memAck && ctrl_q[ON_BIT] |=> memReq && $stable(memAddr)) else $error("request moved");
  chk_read_first: assert property ($rose(memReq) |-> !memWrite) else $error("grant began with write");
  chk_rd_then_wr: assert property (memReq && memAck && !memWrite && !memErr && ctrl_q[ON_BIT] |=> memReq && memWrite) else $error("no write after read");
  chk_wr_ends: assert property (memReq && memAck && memWrite |=> !memReq) else $error("request after write");
  // Register write handshake
  chk_wr_resp: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid) else $error("late write response");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("response dropped");
  cover property (memAck && memWrite);
  cover property (memAck && memErr);
  cover property (ctrl_q[SUSP_BIT] && ctrl_q[ON_BIT]);
endmodule : dmac_core_assertions

/* tb/dmac_mem_model.sv */
// Memory slave answering the DMA master, prompt or slow
`timescale 1ns/1ps
module dmac_mem_model (
  // Clock, reset and pace
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        slow,
  // Master side
  input  wire logic        memReq,
  input  wire logic [31:0] memAddr,
  output logic             memAck,
  output logic             memErr,
  output logic      [31:0] memRdata
);
  logic [1:0] wait_q;
  // Byte at a holds a[7:0]^5A; top nibble F is unmapped
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 2'h0;
      memAck <= 1'b0;
      memErr <= 1'b0;
      memRdata <= 32'h0;
    end else if (memReq && !memAck && (!slow || wait_q == 2'h3)) begin
      wait_q <= 2'h0;
      memAck <= 1'b1;
      memErr <= memAddr[31:28] == 4'hF;
      memRdata <= {memAddr[7:2], 2'h3, memAddr[7:2], 2'h2, memAddr[7:2], 2'h1, memAddr[7:2], 2'h0} ^ 32'h5A5A5A5A;
    end else begin
      wait_q <= (memReq && !memAck) ? wait_q + 2'h1 : 2'h0;
      memAck <= 1'b0;
      memErr <= 1'b0;
      memRdata <= ~memRdata; // Stale data keeps changing
    end
  end
endmodule : dmac_mem_model

/* tb/dma_controller_core_tb.sv */
// Scenario bench for the four-channel DMA core
`timescale 1ns/1ps
module dma_controller_core_tb;
  import dmac_pkg::*;
  logic        mclk = 1'b0, rst_n = 1'b0, slow = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, memReq, memWrite, memAck, memErr;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, memAddr, memWdata, memRdata, lastWd, rdVal;
  logic [3:0]  s_axi_wstrb = 4'hF, memBe, lastBe;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rspVal;
  logic [63:0] irqIn = 64'h0;
  int          mismatches = 0, check_count = 0, cycles = 0;
  dmac_core dmac_core_inst (.*);
  dmac_mem_model dmac_mem_model_inst (.*);
  always #12.5 mclk = ~mclk;
  // Capture completed writes, cut a hung run short
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (memAck && memWrite) {lastWd, lastBe} <= {memWdata, memBe};
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////
  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge mclk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge mclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [11:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rdVal = s_axi_rdata;
    rspVal = s_axi_rresp;
  endtask : bus_rd
  ////////////////////////////////////////////////////////////////
  task automatic t_regs();
    bus_wr(GLB_STAT_OFS, 32'hF);
    bus_rd(GLB_STAT_OFS);
    chk("status", GLB_RST, rdVal);
    bus_rd(12'h040);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rspVal});
    bus_wr(GLB_CTRL_OFS, 32'hFFFF);
    bus_rd(GLB_CTRL_OFS);
    chk("control", 32'h9000, rdVal);
  endtask : t_regs
  task automatic t_move();
    bus_wr(GLB_CTRL_OFS, 32'h8000);
    bus_wr(12'h0A4, 32'h100);
    bus_wr(12'h0A8, 32'h203);
    bus_wr(12'h0AC, 32'h0002_0002);
    bus_wr(12'h0A0, 32'h81);
    do bus_rd(12'h0B4); while (!rdVal[EV_DONE]);
    chk("events", 32'h7C, rdVal);
    chk("byte data", 32'h5B5B_5B5B, lastWd);
    chk("byte lane", 32'h1, {28'h0, lastBe});
    bus_rd(LAST_ADR_OFS);
    chk("last address", 32'h204, rdVal);
    bus_rd(GLB_STAT_OFS);
    chk("status", 32'h1, rdVal);
    bus_wr(12'h0B0, 32'h58);
    bus_wr(12'h0AC, 32'h0004_0004);
    bus_wr(12'h0A0, 32'hA1);
    do bus_rd(12'h0B4); while (!rdVal[EV_PAT]);
    bus_rd(LAST_ADR_OFS);
    chk("pattern stop", 32'h205, rdVal);
  endtask : t_move
  task automatic t_prio();
    slow <= 1'b1;
    bus_wr(GLB_CTRL_OFS, 32'h9000);
    bus_wr(12'h0C4, 32'h300);
    bus_wr(12'h0C8, 32'h600);
    bus_wr(12'h0CC, 32'h0004_0004);
    bus_wr(12'h0C0, 32'h81);
    bus_wr(12'h084, 32'h400);
    bus_wr(12'h088, 32'h500);
    bus_wr(12'h08C, 32'h0004_0004);
    bus_wr(12'h080, 32'h81);
    bus_rd(GLB_CTRL_OFS);
    chk("busy", 32'h9800, rdVal);
    chk("suspended", 32'h0, {31'h0, memReq});
    bus_wr(GLB_CTRL_OFS, 32'h8000);
    do @(posedge mclk); while (!memReq);
    chk("first source", 32'h400, memAddr);
    do bus_rd(12'h0D4); while (!rdVal[EV_DONE]);
    chk("word data", 32'h5958_5B5A, lastWd);
    chk("word lanes", 32'hF, {28'h0, lastBe});
  endtask : t_prio
  task automatic t_irq();
    bus_wr(CKS_CTRL_OFS, 32'h83);
    bus_wr(12'h0E4, 32'h110);
    bus_wr(12'h0E8, 32'h700);
    bus_wr(12'h0EC, 32'h0002_0002);
    bus_wr(12'h0E0, 32'h0909);
    irqIn[9] <= 1'b1;
    do bus_rd(12'h0F4); while (!rdVal[EV_DONE]);
    chk("irq block", 32'h7C, rdVal);
    bus_rd(CKS_SUM_OFS);
    chk("checksum", 32'h95, rdVal);
    irqIn[9] <= 1'b0;
    bus_wr(GLB_CTRL_OFS, 32'h9000);
    bus_wr(12'h0E0, 32'h0005_0091);
    irqIn[5] <= 1'b1;
    do bus_rd(12'h0F4); while (!rdVal[EV_ABORT]);
    bus_rd(12'h0E0);
    chk("abort ctrl", 32'h0005_0010, rdVal);
  endtask : t_irq
  task automatic t_off();
    bus_wr(GLB_CTRL_OFS, 32'h0);
    @(posedge mclk);
    bus_wr(12'h084, 32'hF000_0000);
    bus_wr(12'h080, 32'h81);
    bus_rd(GLB_CTRL_OFS);
    chk("off busy", 32'h0, rdVal);
    chk("off request", 32'h0, {31'h0, memReq});
    bus_wr(GLB_CTRL_OFS, 32'h8000);
    do bus_rd(12'h094); while (!rdVal[EV_ERR]);
    chk("error flags", 32'h7E, rdVal);
    bus_rd(GLB_STAT_OFS);
    chk("read status", 32'h8, rdVal);
  endtask : t_off
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_move();
    t_prio();
    t_irq();
    t_off();
    wrap_up();
  end
endmodule : dma_controller_core_tb
bind dmac_core dmac_core_assertions dmac_core_assertions_inst (.*);
